//--- sser_top.sv
// Status and event reporting block with host command port
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1 - Reading operation event returns latched bits then clears them
// RULE2 - Reading questionable event returns latched bits then clears them
// RULE3 - Condition reads return live bits and change nothing
// RULE4 - Summary bit rises when an enabled event bit is set
// RULE5 - Operation bit 12 reports channel two needs resampling
// RULE6 - Operation bit 10 reports sequence compile finished
// RULE7 - Operation bit 5 reports waiting for trigger
// RULE8 - Questionable bit 14 is command warning; other bits unused
// RULE9 - Preset clears both enable masks
// RULE10 - Events latch only on rising condition edges
// RULE11 - Reset loads enable masks with preset values
// RULE12 - Wait-for-trigger sampled between commands and periodically when idle
// RULE13 - Keep three newest errors, read newest first
// RULE14 - Error entry is number then text; code 0 means empty
// RULE15 - Host writes operation mask only within 0 to 32767
// RULE16 - Unused bits read zero and ignore writes
// RULE17 - Event arriving during clearing read survives for next read
module sser_top
    import sser_pkg::*;
#(
    parameter int SAMPLE_CYC = WAIT_SAMPLE_CYC
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_resample_ch2,
    input  wire logic                  i_compile_done,
    input  wire logic                  i_wait_trig,
    input  wire logic                  i_cmd_warn,
    input  wire logic                  i_cmd_busy,
    input  wire logic                  i_cmd_done,
    input  wire logic                  i_rd,
    input  wire logic                  i_wr,
    input  wire logic                  i_preset,
    input  wire logic [2:0]            i_sel,
    input  wire logic [14:0]           i_wdata,
    input  wire logic                  i_err_push,
    input  wire logic [ERR_CODE_W-1:0] i_err_code,
    input  wire logic [ERR_TEXT_W-1:0] i_err_text,
    output logic      [14:0]           o_rdata,
    output logic                       o_rvalid,
    output logic      [ERR_CODE_W-1:0] o_err_code,
    output logic      [ERR_TEXT_W-1:0] o_err_text,
    output logic                       o_oper_summary,
    output logic                       o_ques_summary
);
    // ------------------------------------------------------------
    // Wait-for-trigger sampling
    // ------------------------------------------------------------
    logic [31:0] samp_cnt_reg;
    logic        wait_trig_reg;
    wire         samp_tick = (samp_cnt_reg == 32'(SAMPLE_CYC - 1));
    wire         samp_now  = i_cmd_done | (!i_cmd_busy & samp_tick);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            samp_cnt_reg  <= 32'h0;
            wait_trig_reg <= 1'b0;
        end else begin
            samp_cnt_reg  <= samp_tick ? 32'h0 : samp_cnt_reg + 32'h1;
            if (samp_now)
                wait_trig_reg <= i_wait_trig; // RULE12
        end
    end

    // ------------------------------------------------------------
    // Condition assembly and decode
    // ------------------------------------------------------------
    logic [14:0] oper_cond;
    logic [14:0] ques_cond;
    always_comb begin
        oper_cond = 15'h0000;
        oper_cond[OPER_BIT_RESAMPLE]  = i_resample_ch2; // RULE5
        oper_cond[OPER_BIT_COMPILE]   = i_compile_done; // RULE6
        oper_cond[OPER_BIT_WAIT_TRIG] = wait_trig_reg; // RULE7
        ques_cond = 15'h0000;
        ques_cond[QUES_BIT_CMD_WARN]  = i_cmd_warn; // RULE8
    end

    wire oper_ev_rd = i_rd & (i_sel == SEL_OPER_EVENT);
    wire ques_ev_rd = i_rd & (i_sel == SEL_QUES_EVENT);
    wire oper_mk_wr = i_wr & (i_sel == SEL_OPER_MASK);
    wire ques_mk_wr = i_wr & (i_sel == SEL_QUES_MASK);
    wire err_rd     = i_rd & (i_sel == SEL_ERR_READ);

    logic [14:0] oc, oe, om, qc, qe, qm;
    logic        os, qs;

    sser_group #(.IMPL(OPER_IMPL_MASK)) u_oper (
        .i_core_clk   (i_core_clk),
        .i_nrst       (i_nrst),
        .i_cond       (oper_cond),
        .i_preset     (i_preset),
        .i_mask_wr    (oper_mk_wr),
        .i_mask_wdata (i_wdata),
        .i_event_rd   (oper_ev_rd), // RULE1 RULE17
        .o_cond       (oc),
        .o_event      (oe),
        .o_mask       (om),
        .o_summary    (os)
    );

    sser_group #(.IMPL(QUES_IMPL_MASK)) u_ques (
        .i_core_clk   (i_core_clk),
        .i_nrst       (i_nrst),
        .i_cond       (ques_cond),
        .i_preset     (i_preset),
        .i_mask_wr    (ques_mk_wr),
        .i_mask_wdata (i_wdata),
        .i_event_rd   (ques_ev_rd), // RULE2 RULE17
        .o_cond       (qc),
        .o_event      (qe),
        .o_mask       (qm),
        .o_summary    (qs)
    );

    sser_errq u_errq (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_push     (i_err_push),
        .i_code     (i_err_code),
        .i_text     (i_err_text),
        .i_pop      (err_rd),
        .o_code     (o_err_code),
        .o_text     (o_err_text)
    );

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    logic [14:0] rd_mux;
    always_comb begin
        case (i_sel)
            SEL_OPER_COND:  rd_mux = oc; // RULE3
            SEL_OPER_EVENT: rd_mux = oe;
            SEL_OPER_MASK:  rd_mux = om;
            SEL_QUES_COND:  rd_mux = qc; // RULE3
            SEL_QUES_EVENT: rd_mux = qe;
            SEL_QUES_MASK:  rd_mux = qm;
            default:        rd_mux = 15'h0000;
        endcase
    end

    logic [14:0] rdata_reg;
    logic        rvalid_reg;
    logic        os_reg;
    logic        qs_reg;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg  <= 15'h0000;
            rvalid_reg <= 1'b0;
            os_reg     <= 1'b0;
            qs_reg     <= 1'b0;
        end else begin
            if (i_rd)
                rdata_reg <= rd_mux;
            rvalid_reg <= i_rd;
            os_reg     <= os;
            qs_reg     <= qs;
        end
    end

    assign o_rdata        = rdata_reg;
    assign o_rvalid       = rvalid_reg;
    assign o_oper_summary = os_reg;
    assign o_ques_summary = qs_reg;
endmodule
`default_nettype wire

//--- sser_pkg.sv
// Package of constants for the status and event reporting block
package sser_pkg;
    localparam int STAT_W = 15;
    localparam int ERR_CODE_W = 16;
    localparam int ERR_TEXT_W = 8;
    localparam int ERR_DEPTH = 3;
    // Register selects of the host command port
    localparam logic [2:0] SEL_OPER_COND  = 3'h0;
    localparam logic [2:0] SEL_OPER_EVENT = 3'h1;
    localparam logic [2:0] SEL_OPER_MASK  = 3'h2;
    localparam logic [2:0] SEL_QUES_COND  = 3'h3;
    localparam logic [2:0] SEL_QUES_EVENT = 3'h4;
    localparam logic [2:0] SEL_QUES_MASK  = 3'h5;
    localparam logic [2:0] SEL_ERR_READ   = 3'h6;
    // Implemented bits of each group
    localparam logic [14:0] OPER_IMPL_MASK = 15'h1420;
    localparam logic [14:0] QUES_IMPL_MASK = 15'h4000;
    localparam int OPER_BIT_RESAMPLE = 12;
    localparam int OPER_BIT_COMPILE  = 10;
    localparam int OPER_BIT_WAIT_TRIG = 5;
    localparam int QUES_BIT_CMD_WARN = 14;
    // Preset state of the enable masks
    localparam logic [14:0] MASK_PRESET = 15'h0000;
    // Empty-history entry
    localparam logic [15:0] ERR_NONE_CODE = 16'h0000;
    localparam logic [7:0]  ERR_NONE_TEXT = 8'h00;
    // Idle sampling of the wait-for-trigger flag: 2.5 ms at 250 MHz
    localparam int WAIT_SAMPLE_US = 2500;
    localparam int CLK_MHZ = 250;
    localparam int WAIT_SAMPLE_CYC = WAIT_SAMPLE_US * CLK_MHZ;
endpackage

//--- sser_group.sv
// One status group: condition, latched event, mask and summary
`timescale 1ns/1ns
`default_nettype none
module sser_group
    import sser_pkg::*;
#(
    parameter logic [14:0] IMPL = 15'h7fff
) (
    input  wire logic          i_core_clk,
    input  wire logic          i_nrst,
    input  wire logic [14:0]   i_cond,
    input  wire logic          i_preset,
    input  wire logic          i_mask_wr,
    input  wire logic [14:0]   i_mask_wdata,
    input  wire logic          i_event_rd,
    output logic      [14:0]   o_cond,
    output logic      [14:0]   o_event,
    output logic      [14:0]   o_mask,
    output logic               o_summary
);
    logic [14:0] cond_reg;
    logic [14:0] event_reg;
    logic [14:0] mask_reg;
    logic        summary_reg;
    wire  [14:0] cond_live = i_cond & IMPL;
    wire  [14:0] rise      = cond_live & ~cond_reg;
    wire  [14:0] event_next = (i_event_rd ? 15'h0000 : event_reg) | rise;
    wire  [14:0] mask_next = i_preset ? MASK_PRESET :
                             (i_mask_wr ? (i_mask_wdata & IMPL) : mask_reg);
    wire         summary_next = |(event_next & mask_next);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cond_reg    <= 15'h0000;
            event_reg   <= 15'h0000;
            mask_reg    <= MASK_PRESET; // RULE11
            summary_reg <= 1'b0;
        end else begin
            cond_reg    <= cond_live; // RULE16
            event_reg   <= event_next; // RULE10
            mask_reg    <= mask_next; // RULE9
            summary_reg <= summary_next; // RULE4
        end
    end

    assign o_cond    = cond_reg;
    assign o_event   = event_reg;
    assign o_mask    = mask_reg;
    assign o_summary = summary_reg;
endmodule
`default_nettype wire

//--- sser_errq.sv
// Three-entry error history, newest first, registered read data
`timescale 1ns/1ns
`default_nettype none
module sser_errq
    import sser_pkg::*;
#(
    parameter int DEPTH = ERR_DEPTH
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_push,
    input  wire logic [ERR_CODE_W-1:0] i_code,
    input  wire logic [ERR_TEXT_W-1:0] i_text,
    input  wire logic                  i_pop,
    output logic      [ERR_CODE_W-1:0] o_code,
    output logic      [ERR_TEXT_W-1:0] o_text
);
    logic [ERR_CODE_W-1:0] code_mem [DEPTH];
    logic [ERR_TEXT_W-1:0] text_mem [DEPTH];
    logic [DEPTH-1:0]      valid_reg;
    logic [ERR_CODE_W-1:0] code_reg;
    logic [ERR_TEXT_W-1:0] text_reg;

    // Slot 0 holds the newest error
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_slot
            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    code_mem[g]  <= '0;
                    text_mem[g]  <= '0;
                    valid_reg[g] <= 1'b0;
                end else if (i_push) begin
                    code_mem[g]  <= (g == 0) ? i_code : code_mem[(g == 0) ? 0 : g-1];
                    text_mem[g]  <= (g == 0) ? i_text : text_mem[(g == 0) ? 0 : g-1];
                    valid_reg[g] <= (g == 0) ? 1'b1 : valid_reg[(g == 0) ? 0 : g-1];
                end else if (i_pop) begin
                    code_mem[g]  <= (g == DEPTH-1) ? '0 : code_mem[(g == DEPTH-1) ? g : g+1];
                    text_mem[g]  <= (g == DEPTH-1) ? '0 : text_mem[(g == DEPTH-1) ? g : g+1];
                    valid_reg[g] <= (g == DEPTH-1) ? 1'b0
                                    : valid_reg[(g == DEPTH-1) ? g : g+1];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            code_reg <= ERR_NONE_CODE;
            text_reg <= ERR_NONE_TEXT;
        end else if (i_pop) begin
            code_reg <= valid_reg[0] ? code_mem[0] : ERR_NONE_CODE; // RULE14
            text_reg <= valid_reg[0] ? text_mem[0] : ERR_NONE_TEXT; // RULE13
        end
    end

    assign o_code = code_reg;
    assign o_text = text_reg;
endmodule
`default_nettype wire

//--- sser_assertions.sv
// Port checks of the status and event reporting block
`timescale 1ns/1ns
`default_nettype none
module sser_chk
    import sser_pkg::*;
#(
    parameter int SAMPLE_CYC = WAIT_SAMPLE_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_resample_ch2,
    input  wire logic        i_compile_done,
    input  wire logic        i_cmd_warn,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic        i_preset,
    input  wire logic [2:0]  i_sel,
    input  wire logic [14:0] i_wdata,
    input  wire logic [14:0] o_rdata,
    input  wire logic        o_rvalid,
    input  wire logic        o_oper_summary,
    input  wire logic        o_ques_summary
);
    logic [14:0] op_mask_reg;
    logic [14:0] op_mask_next;
    logic [14:0] qu_mask_reg;
    logic [14:0] qu_mask_next;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // ----------------------------------------
    // Mask mirrors
    // ----------------------------------------
    assign op_mask_next = i_preset ? MASK_PRESET : (i_wr && i_sel == SEL_OPER_MASK) ?
        (i_wdata & OPER_IMPL_MASK) : op_mask_reg;
    assign qu_mask_next = i_preset ? MASK_PRESET : (i_wr && i_sel == SEL_QUES_MASK) ?
        (i_wdata & QUES_IMPL_MASK) : qu_mask_reg;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            op_mask_reg <= MASK_PRESET;
            qu_mask_reg <= MASK_PRESET;
        end else begin
            op_mask_reg <= op_mask_next;
            qu_mask_reg <= qu_mask_next;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence rd_taken;
        i_rd;
    endsequence
    sequence ques_ev_hit;
        o_rvalid && $past(i_sel) == SEL_QUES_EVENT && |(o_rdata & $past(qu_mask_reg));
    endsequence
    read_answer_a: assert property (rd_taken |=> o_rvalid)
        else $error("read not answered");
    no_spurious_a: assert property (!i_rd |=> !o_rvalid)
        else $error("unrequested read valid");
    rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved");
    oper_cond_a: assert property (
        o_rvalid && $past(i_sel) == SEL_OPER_COND && $past(i_nrst, 2)
        |-> (o_rdata & 15'h1400) == {2'h0, $past(i_resample_ch2, 2), 1'b0,
        $past(i_compile_done, 2), 10'h000})
        else $error("oper condition wrong");
    ques_cond_a: assert property (
        o_rvalid && $past(i_sel) == SEL_QUES_COND && $past(i_nrst, 2)
        |-> o_rdata == {$past(i_cmd_warn, 2), 14'h0000})
        else $error("ques condition wrong");
    unused_zero_a: assert property (
        o_rvalid && $past(i_sel) < 3'h3 |-> (o_rdata & ~OPER_IMPL_MASK) == 15'h0000)
        else $error("unused oper bit set");
    oper_quiet_a: assert property (
        (op_mask_reg == 15'h0000)[*4] |-> !o_oper_summary)
        else $error("oper summary with zero mask");
    ques_quiet_a: assert property (
        (qu_mask_reg == 15'h0000)[*4] |-> !o_ques_summary)
        else $error("ques summary with zero mask");
    summary_rise_a: assert property (ques_ev_hit |-> o_ques_summary)
        else $error("ques summary missing");
endmodule
bind sser_top sser_chk #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.i_core_clk, .i_nrst,
    .i_resample_ch2, .i_compile_done, .i_cmd_warn, .i_rd, .i_wr, .i_preset, .i_sel,
    .i_wdata, .o_rdata, .o_rvalid, .o_oper_summary, .o_ques_summary);
`default_nettype wire

//--- sser_host.sv
// Host controller model issuing register commands
`timescale 1ns/1ns
`default_nettype none
module sser_host (
    input  wire logic        i_core_clk,
    output logic             o_rd,
    output logic             o_wr,
    output logic             o_preset,
    output logic      [2:0]  o_sel,
    output logic      [14:0] o_wdata
);
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_preset = 1'b0;
        o_sel = 3'h0;
        o_wdata = 15'h0000;
    end
    // One-cycle command, lines scrambled once released
    task automatic pulse(input logic rd, input logic wr, input logic pre,
                         input logic [2:0] sel, input logic [14:0] wd);
        @(posedge i_core_clk);
        #1;
        o_rd = rd;
        o_wr = wr;
        o_preset = pre;
        o_sel = sel;
        o_wdata = wd;
        @(posedge i_core_clk);
        #1;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_preset = 1'b0;
        o_sel = ~o_sel;
        o_wdata = ~o_wdata;
    endtask
endmodule
`default_nettype wire

//--- sser_top_test.sv
// Testbench of the status and event reporting block
`timescale 1ns/1ns
`default_nettype none
module sser_top_test;
    import sser_pkg::*;
    logic        i_core_clk, i_nrst, i_resample_ch2, i_compile_done, i_wait_trig;
    logic        i_cmd_warn, i_cmd_busy, i_cmd_done, i_rd, i_wr, i_preset, i_err_push;
    logic [2:0]  i_sel;
    logic [14:0] i_wdata, o_rdata;
    logic [15:0] i_err_code, o_err_code;
    logic [7:0]  i_err_text, o_err_text;
    logic        o_rvalid, o_oper_summary, o_ques_summary;
    int          bad_count = 0;
    int          check_count = 0;
    sser_top #(.SAMPLE_CYC(8)) DUT (.i_core_clk, .i_nrst, .i_resample_ch2,
        .i_compile_done, .i_wait_trig, .i_cmd_warn, .i_cmd_busy, .i_cmd_done, .i_rd,
        .i_wr, .i_preset, .i_sel, .i_wdata, .i_err_push, .i_err_code, .i_err_text,
        .o_rdata, .o_rvalid, .o_err_code, .o_err_text, .o_oper_summary, .o_ques_summary);
    sser_host u_host (.i_core_clk, .o_rd(i_rd), .o_wr(i_wr), .o_preset(i_preset),
        .o_sel(i_sel), .o_wdata(i_wdata));
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [2:0] s, input logic [15:0] e, input string nm);
        u_host.pulse(1'b1, 1'b0, 1'b0, s, 15'h0000);
        chk(nm, e, {1'b0, o_rdata});
        chk({nm, " valid"}, 16'h0001, {15'h0000, o_rvalid});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic t_oper;
        rdc(SEL_OPER_MASK, 16'h0000, "oper mask");
        rdc(3'h7, 16'h0000, "sel 7");
        i_resample_ch2 = 1'b1;
        i_compile_done = 1'b1;
        cyc(3);
        rdc(SEL_OPER_COND, 16'h1400, "oper cond");
        rdc(SEL_OPER_EVENT, 16'h1400, "oper event");
        rdc(SEL_OPER_EVENT, 16'h0000, "oper cleared");
        i_resample_ch2 = 1'b0;
        i_compile_done = 1'b0;
        cyc(3);
        rdc(SEL_OPER_EVENT, 16'h0000, "falling");
        fork
            u_host.pulse(1'b1, 1'b0, 1'b0, SEL_OPER_EVENT, 15'h0000);
            begin
                @(posedge i_core_clk);
                #1;
                i_resample_ch2 = 1'b1;
            end
        join
        chk("race old", 16'h0000, {1'b0, o_rdata});
        rdc(SEL_OPER_EVENT, 16'h1000, "race");
        i_resample_ch2 = 1'b0;
        $display("test oper done");
    endtask
    task automatic t_trig(input logic b);
        i_cmd_busy = b;
        i_wait_trig = 1'b1;
        cyc(20);
        rdc(SEL_OPER_EVENT, b ? 16'h0000 : 16'h0020, "idle sample");
        i_cmd_done = 1'b1;
        cyc(1);
        i_cmd_done = 1'b0;
        cyc(4);
        rdc(SEL_OPER_EVENT, b ? 16'h0020 : 16'h0000, "done sample");
        i_wait_trig = 1'b0;
        i_cmd_busy = 1'b0;
        cyc(20);
        $display("test trig done");
    endtask
    task automatic t_ques;
        u_host.pulse(1'b0, 1'b1, 1'b0, SEL_QUES_MASK, 15'h7fff);
        rdc(SEL_QUES_MASK, 16'h4000, "ques mask");
        u_host.pulse(1'b0, 1'b1, 1'b0, SEL_OPER_MASK, 15'h7fff);
        rdc(SEL_OPER_MASK, 16'h1420, "oper mask");
        i_cmd_warn = 1'b1;
        i_compile_done = 1'b1;
        cyc(5);
        chk("summary", 16'h0001, {15'h0000, o_ques_summary});
        chk("oper summary", 16'h0001, {15'h0000, o_oper_summary});
        rdc(SEL_QUES_COND, 16'h4000, "ques cond");
        rdc(SEL_QUES_EVENT, 16'h4000, "ques event");
        rdc(SEL_QUES_EVENT, 16'h0000, "ques cleared");
        u_host.pulse(1'b0, 1'b0, 1'b1, 3'h0, 15'h0000);
        rdc(SEL_QUES_MASK, 16'h0000, "ques preset");
        rdc(SEL_OPER_MASK, 16'h0000, "oper preset");
        chk("oper sum preset", 16'h0000, {15'h0000, o_oper_summary});
        chk("ques sum preset", 16'h0000, {15'h0000, o_ques_summary});
        i_cmd_warn = 1'b0;
        i_compile_done = 1'b0;
        $display("test ques done");
    endtask
    task automatic t_rst;
        u_host.pulse(1'b0, 1'b1, 1'b0, SEL_QUES_MASK, 15'h4000);
        cyc(1);
        i_nrst = 1'b0;
        cyc(2);
        i_nrst = 1'b1;
        rdc(SEL_QUES_MASK, 16'h0000, "mask after reset");
        $display("test rst done");
    endtask
    task automatic t_err;
        for (int k = 1; k < 5; k++) begin
            i_err_push = 1'b1;
            i_err_code = 16'(k);
            i_err_text = 8'(k + 16);
            cyc(1);
        end
        i_err_push = 1'b0;
        for (int k = 4; k > 0; k--) begin
            u_host.pulse(1'b1, 1'b0, 1'b0, SEL_ERR_READ, 15'h0000);
            chk("err code", (k > 1) ? 16'(k) : ERR_NONE_CODE, o_err_code);
            chk("err text", (k > 1) ? 16'(k + 16) : 16'(ERR_NONE_TEXT), 16'(o_err_text));
        end
        $display("test err done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        i_nrst = 1'b0;
        {i_resample_ch2, i_compile_done, i_wait_trig, i_cmd_warn} = 4'h0;
        {i_cmd_busy, i_cmd_done, i_err_push} = 3'h0;
        i_err_code = 16'h0000;
        i_err_text = 8'h00;
        cyc(8);
        i_nrst = 1'b1;
        t_oper;
        t_trig(1'b0);
        t_trig(1'b1);
        t_ques;
        t_err;
        t_rst;
        print_verdict;
    end
endmodule
`default_nettype wire
